// >>> src/lius_host_port.sv
module lius_host_port
  import lius_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Device pins
  input wire lius_pin_s pins_i,
  output logic shared_o,
  output logic shared_oe_o,
  output logic [7:0] d_o,
  output logic d_oe_o,
  output logic irq_n_o,
  output logic irq_n_oe_o,
  // Line-side controls and interrupt
  output logic rx_term_off_o,
  output lius_lb_e [LIUS_CH_N-1:0] loopback_o,
  output logic irq_o
);
  typedef struct packed {
    logic [LIUS_PIN_W-1:0] s1;
    logic [LIUS_PIN_W-1:0] s2;
    logic [LIUS_PIN_W-1:0] s3;
    logic [LIUS_PIN_W-1:0] filt;
    logic [LIUS_PIN_W-1:0] fprev;
    lius_ser_e ser_st;
    logic [3:0] scnt;
    logic [3:0] ocnt;
    logic [7:0] sh;
    logic [7:0] cmd;
    logic [7:0] rbuf;
    logic [7:0] rd_byte;
    lius_par_e pst;
    logic [3:0] pcnt;
    logic is_rd;
    logic [LIUS_AW-1:0] paddr;
    logic [LIUS_NREG-1:0][7:0] mem;
    logic drv_hi;
    logic [LIUS_EV_W-1:0] istat;
    logic [LIUS_EV_W-1:0] imask;
    logic [31:0] rdata;
    logic shared;
    logic shared_oe;
    logic [7:0] d_out;
    logic d_oe;
    logic irq_n;
    logic irq_n_oe;
    logic irq;
    logic rx_off;
    lius_lb_e [LIUS_CH_N-1:0] lb;
  } lius_st_s;

  localparam logic [3:0] ACC_LAST = 4'(LIUS_ACC_CYC - 1);

  lius_st_s st_reg;
  lius_st_s st_next;
  lius_pin_s f;
  lius_pin_s fp;
  logic sclk_rise;
  logic sclk_fall;
  logic launch;
  logic is_par;
  logic [LIUS_EV_W-1:0] ev;
  logic [LIUS_PIN_W-1:0] agree;
  logic [7:0] nsh;

  // ************
  // Next state
  // ************
  always_comb begin
    st_next = st_reg;
    ev = '0;
    nsh = '0;
    // Three-stage sampling; a bit moves only when stages two and three agree
    st_next.s1 = pins_i;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    agree = ~(st_reg.s2 ^ st_reg.s3);
    st_next.filt = (st_reg.filt & ~agree) | (st_reg.s3 & agree);
    st_next.fprev = st_reg.filt;
    f = lius_pin_s'(st_reg.filt);
    fp = lius_pin_s'(st_reg.fprev);
    sclk_rise = f.sclk & ~fp.sclk;
    sclk_fall = ~f.sclk & fp.sclk;
    launch = f.edge_sel ? sclk_fall : sclk_rise;
    is_par = (f.mode == LIUS_NONMUX) || (f.mode == LIUS_MUX);

    // Serial host: command byte, then one data byte in or out
    if (f.mode != LIUS_SERIAL || f.scs_n) begin
      if (st_reg.ser_st == LIUS_SER_RDATA && f.mode == LIUS_SERIAL) begin
        ev[LIUS_EV_SER] = 1'b1;
      end
      st_next.ser_st = LIUS_SER_CMD;
      st_next.scnt = '0;
      st_next.ocnt = '0;
    end else begin
      if (sclk_rise && st_reg.ser_st != LIUS_SER_RDATA) begin
        nsh = {f.serial_in, st_reg.sh[7:1]};
        st_next.sh = nsh;
        st_next.scnt = st_reg.scnt + 4'h1;
        if (st_reg.scnt == LIUS_BITS_LAST) begin
          st_next.scnt = '0;
          if (st_reg.ser_st == LIUS_SER_WDATA) begin
            st_next.mem[st_reg.cmd[LIUS_AW:1]] = nsh;
            ev[LIUS_EV_SER] = 1'b1;
            st_next.ser_st = LIUS_SER_CMD;
          end else if (nsh[0]) begin
            st_next.cmd = nsh;
            st_next.rbuf = st_reg.mem[nsh[LIUS_AW:1]];
            st_next.rd_byte = st_reg.mem[nsh[LIUS_AW:1]];
            st_next.ser_st = LIUS_SER_RDATA;
          end else begin
            st_next.cmd = nsh;
            st_next.ser_st = LIUS_SER_WDATA;
          end
        end
      end
      // First launch edge after the command opens the pin
      if (launch && st_reg.ser_st == LIUS_SER_RDATA) begin
        st_next.shared = st_reg.rbuf[0];
        st_next.rbuf = {1'b0, st_reg.rbuf[7:1]};
        st_next.ocnt = st_reg.ocnt + 4'h1;
      end
    end

    // Parallel host: address from pins or latched off the bus
    if (f.mode == LIUS_MUX && fp.ale && !f.ale) begin
      st_next.paddr = f.d[LIUS_AW-1:0];
    end
    case (st_reg.pst)
      LIUS_P_IDLE: begin
        if (is_par && !f.pcs_n && (!f.prd_n || !f.pwr_n)) begin
          st_next.is_rd = !f.prd_n;
          st_next.pcnt = ACC_LAST;
          if (f.mode == LIUS_NONMUX) begin
            st_next.paddr = f.addr;
          end
          st_next.pst = LIUS_P_BUSY;
        end
      end
      LIUS_P_BUSY: begin
        st_next.pcnt = st_reg.pcnt - 4'h1;
        if (st_reg.pcnt == '0) begin
          if (st_reg.is_rd) begin
            st_next.d_out = st_reg.mem[st_reg.paddr];
            st_next.d_oe = 1'b1;
          end else begin
            st_next.mem[st_reg.paddr] = f.d;
          end
          ev[LIUS_EV_PAR] = 1'b1;
          st_next.pst = LIUS_P_HOLD;
        end
      end
      LIUS_P_HOLD: begin
        // Data stays on the bus until the host lets the strobe go
        if (f.pcs_n || (f.prd_n && f.pwr_n)) begin
          st_next.d_oe = 1'b0;
          st_next.pst = LIUS_P_IDLE;
        end
      end
      default: begin
        st_next.pst = LIUS_P_IDLE;
      end
    endcase

    // Shared pin: serial data, ready, acknowledge, or hardware input
    if (f.mode == LIUS_SERIAL) begin
      st_next.shared_oe = st_next.ser_st == LIUS_SER_RDATA && st_next.ocnt != '0;
    end else if (is_par) begin
      st_next.shared_oe = !f.pcs_n || st_next.pst != LIUS_P_IDLE;
      if (f.ack_style) begin
        st_next.shared = st_next.pst != LIUS_P_HOLD;
      end else begin
        st_next.shared = st_next.pst != LIUS_P_BUSY;
      end
    end else begin
      st_next.shared_oe = 1'b0;
    end
    if (!is_par) begin
      st_next.d_oe = 1'b0;
    end

    // Hardware mode: termination and three-level loopback selects
    st_next.rx_off = f.mode == LIUS_HW && f.shared;
    for (int i = 0; i < LIUS_CH_N; i++) begin
      if (f.mode != LIUS_HW || f.lp_mid[i]) begin
        st_next.lb[i] = LIUS_LB_NONE;
      end else if (f.d[i]) begin
        st_next.lb[i] = LIUS_LB_ANALOG;
      end else begin
        st_next.lb[i] = LIUS_LB_REMOTE;
      end
    end
    if (f.mode == LIUS_HW && (st_next.lb != st_reg.lb || st_next.rx_off != st_reg.rx_off)) begin
      ev[LIUS_EV_HW] = 1'b1;
    end

    // Register port; a new event wins over a write-one clear
    st_next.rdata = '0;
    if (reg_wr_i) begin
      if (reg_addr_i == LIUS_CTRL_OFS) begin
        st_next.drv_hi = reg_wdata_i[LIUS_CTRL_DRV_HI];
        if (reg_wdata_i[LIUS_CTRL_SRST]) begin
          st_next.imask = LIUS_MASK_RST;
        end
      end else if (reg_addr_i == LIUS_ISTAT_OFS) begin
        st_next.istat = st_reg.istat & ~reg_wdata_i[LIUS_EV_W-1:0];
      end else if (reg_addr_i == LIUS_IMASK_OFS) begin
        st_next.imask = reg_wdata_i[LIUS_EV_W-1:0];
      end
    end
    if (reg_rd_i) begin
      if (reg_addr_i == LIUS_CTRL_OFS) begin
        st_next.rdata[LIUS_CTRL_DRV_HI] = st_reg.drv_hi;
      end else if (reg_addr_i == LIUS_ISTAT_OFS) begin
        st_next.rdata[LIUS_EV_W-1:0] = st_reg.istat;
      end else if (reg_addr_i == LIUS_IMASK_OFS) begin
        st_next.rdata[LIUS_EV_W-1:0] = st_reg.imask;
      end else if (reg_addr_i == LIUS_STAT_OFS) begin
        st_next.rdata[4:0] = {st_reg.ser_st == LIUS_SER_RDATA, st_reg.pst != LIUS_P_IDLE,
                              st_reg.rx_off, f.mode};
      end
    end
    st_next.istat = st_next.istat | ev;

    // Open-drain interrupt; floats when idle unless drive-high is set
    st_next.irq = |(st_next.istat & st_next.imask);
    st_next.irq_n = !st_next.irq;
    st_next.irq_n_oe = st_next.irq || st_next.drv_hi;
  end

  // ************
  // State register
  // ************
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata_o = st_reg.rdata;
  assign shared_o = st_reg.shared;
  assign shared_oe_o = st_reg.shared_oe;
  assign d_o = st_reg.d_out;
  assign d_oe_o = st_reg.d_oe;
  assign irq_n_o = st_reg.irq_n;
  assign irq_n_oe_o = st_reg.irq_n_oe;
  assign irq_o = st_reg.irq;
  assign rx_term_off_o = st_reg.rx_off;
  assign loopback_o = st_reg.lb;

  // ************
  // Checks
  // ************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  ser_cmd_float_a: assert property (f.mode == LIUS_SERIAL && st_reg.ser_st == LIUS_SER_CMD
    |=> !shared_oe_o) else $error("serial_out driven during command");
  ser_wr_float_a: assert property (st_reg.ser_st == LIUS_SER_WDATA |-> !shared_oe_o)
    else $error("serial_out driven during write");
  ser_lsb_a: assert property (f.mode == LIUS_SERIAL && $rose(shared_oe_o)
    |-> shared_o == st_reg.rd_byte[0]) else $error("first read bit not LSB");
  ser_edge_a: assert property (f.mode == LIUS_SERIAL && st_reg.ocnt != $past(st_reg.ocnt)
    && st_reg.ocnt != '0 |-> $past(launch)) else $error("bit launched on wrong edge");
  ready_low_a: assert property (is_par && !f.ack_style && st_reg.pst == LIUS_P_BUSY
    && st_next.pst == LIUS_P_BUSY |=> shared_oe_o && !shared_o)
    else $error("ready high during pending access");
  ack_low_a: assert property (is_par && f.ack_style && st_reg.pst == LIUS_P_BUSY
    && st_reg.pcnt == '0 |=> shared_oe_o && !shared_o)
    else $error("acknowledge missing at completion");
  par_rd_drive_a: assert property (st_reg.pst == LIUS_P_BUSY && st_reg.pcnt == '0
    && st_reg.is_rd && is_par |=> d_oe_o) else $error("read data not driven");
  mux_addr_a: assert property (f.mode == LIUS_MUX && fp.ale && !f.ale
    && st_reg.pst == LIUS_P_IDLE |=> st_reg.paddr == $past(f.d[LIUS_AW-1:0]))
    else $error("multiplexed address not latched");
  rx_term_a: assert property (f.mode == LIUS_HW && f.shared |=> rx_term_off_o)
    else $error("termination not switched off");
  irq_low_a: assert property (|(st_reg.istat & st_reg.imask) |-> irq_n_oe_o && !irq_n_o)
    else $error("interrupt pin not pulled low");
  irq_float_a: assert property (!irq_o && !st_reg.drv_hi |-> !irq_n_oe_o)
    else $error("interrupt pin driven while idle");
  srst_mask_a: assert property (reg_wr_i && reg_addr_i == LIUS_CTRL_OFS
    && reg_wdata_i[LIUS_CTRL_SRST] |=> st_reg.imask == '0)
    else $error("sources still enabled after soft reset");
  lb_none_a: assert property (f.mode == LIUS_HW && f.lp_mid[0]
    |=> loopback_o[0] == LIUS_LB_NONE) else $error("mid level not no-loopback");

  ser_read_c: cover property (st_reg.ser_st == LIUS_SER_RDATA && st_reg.ocnt == 4'h8);
  par_ack_c: cover property (f.ack_style && st_reg.pst == LIUS_P_HOLD && !st_reg.is_rd);
  irq_c: cover property ($rose(irq_o));
endmodule

// >>> include/lius_pkg.sv
package lius_pkg;
  // ************
  // Host modes, loopback codes and host state encodings
  // ************
  typedef enum logic [1:0] {LIUS_SERIAL, LIUS_NONMUX, LIUS_MUX, LIUS_HW} lius_mode_e;
  typedef enum logic [1:0] {LIUS_LB_REMOTE, LIUS_LB_NONE, LIUS_LB_ANALOG} lius_lb_e;
  typedef enum logic [1:0] {LIUS_SER_CMD, LIUS_SER_WDATA, LIUS_SER_RDATA} lius_ser_e;
  typedef enum logic [1:0] {LIUS_P_IDLE, LIUS_P_BUSY, LIUS_P_HOLD} lius_par_e;

  // ************
  // Sizes and register map
  // ************
  localparam int LIUS_CH_N = 8;
  localparam int LIUS_AW = 3;
  localparam int LIUS_NREG = 8;
  localparam int LIUS_EV_W = 3;
  localparam logic [3:0] LIUS_CTRL_OFS = 4'h0;
  localparam logic [3:0] LIUS_ISTAT_OFS = 4'h4;
  localparam logic [3:0] LIUS_IMASK_OFS = 4'h8;
  localparam logic [3:0] LIUS_STAT_OFS = 4'hC;
  localparam int LIUS_CTRL_DRV_HI = 0;
  localparam int LIUS_CTRL_SRST = 1;
  localparam int LIUS_EV_SER = 0;
  localparam int LIUS_EV_PAR = 1;
  localparam int LIUS_EV_HW = 2;
  localparam logic [LIUS_EV_W-1:0] LIUS_MASK_RST = 3'h0;
  localparam logic [3:0] LIUS_BITS_LAST = 4'h7;

  // ************
  // Timing
  // ************
  localparam int LIUS_CLK_NS = 10;
  localparam int LIUS_ACC_NS = 40;
  localparam int LIUS_ACC_CYC = (LIUS_ACC_NS + LIUS_CLK_NS - 1) / LIUS_CLK_NS;

  // Pin bundle seen by the block, all from outside the clock domain
  typedef struct packed {
    lius_mode_e mode;
    logic ack_style;
    logic edge_sel;
    logic sclk;
    logic serial_in;
    logic scs_n;
    logic pcs_n;
    logic prd_n;
    logic pwr_n;
    logic ale;
    logic shared;
    logic [LIUS_AW-1:0] addr;
    logic [7:0] d;
    logic [LIUS_CH_N-1:0] lp_mid;
  } lius_pin_s;
  localparam int LIUS_PIN_W = $bits(lius_pin_s);
endpackage

// >>> testbench/lius_host_model.sv
module lius_host_model
  import lius_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Levels the device drives
  input wire logic shared_o,
  input wire logic shared_oe_o,
  input wire logic [7:0] d_o,
  input wire logic d_oe_o,
  // Resolved pins seen by the device
  output lius_pin_s pins_o
);
  timeunit 1ns;
  timeprecision 100ps;
  lius_pin_s drv;
  logic sh_last = 1'h0;

  // Outside hardware mode a released shared line shows the inverse of its last level, so stale bits never pass
  always_comb begin
    pins_o = drv;
    pins_o.shared = shared_oe_o ? shared_o : (drv.mode == LIUS_HW ? drv.shared : ~sh_last);
    pins_o.d = d_oe_o ? d_o : drv.d;
  end

  // Last level of the shared line; idle strobes high, bus lines low
  always @(posedge clk_i) begin
    sh_last <= pins_o.shared;
  end
  initial begin
    drv = '0;
    drv.scs_n = 1'h1;
    drv.pcs_n = 1'h1;
    drv.prd_n = 1'h1;
    drv.pwr_n = 1'h1;
    drv.d = 8'h00;
  end

  // ************
  // Host transfers
  // ************
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Serial frame with an 80 ns clock; each bit is sampled 7.5 cycles after its launch
  task automatic ser_frame(input logic [7:0] cmd, input logic [7:0] wdat,
                           output logic [7:0] rdat, output logic bad);
    logic [16:0] bits;
    logic [7:0] fall_s;
    bits = {1'h0, wdat, cmd};
    fall_s = 8'h00;
    rdat = 8'h00;
    bad = 1'h0;
    @(posedge clk_i);
    drv.scs_n <= 1'h0;
    for (int p = 0; p < 17; p++) begin
      drv.serial_in <= bits[p];
      wait_clk(3);
      @(negedge clk_i);
      // Just before the rise both edge modes still show bit p-9
      if (p > 8) rdat[p-9] = pins_o.shared;
      bad |= shared_oe_o && (p < 8 || !cmd[0]);
      @(posedge clk_i);
      drv.sclk <= 1'h1;
      wait_clk(3);
      @(negedge clk_i);
      // Just before the fall a wrong launch edge shows the neighbouring bit
      if (!drv.edge_sel && p > 8) fall_s[p-9] = pins_o.shared;
      if (drv.edge_sel && p > 7 && p < 16) fall_s[p-8] = pins_o.shared;
      bad |= shared_oe_o && (p < 8 || !cmd[0]);
      @(posedge clk_i);
      drv.sclk <= 1'h0;
    end
    if (cmd[0] && fall_s !== rdat) bad = 1'h1;
    drv.scs_n <= 1'h1;
    wait_clk(12);
  endtask

  // Parallel access; lo counts cycles the shared pin was driven low
  task automatic par_acc(input logic wr, input logic [7:0] adr, input logic [7:0] wdat,
                         output logic [7:0] rdat, output logic [7:0] lo);
    lo = 8'h00;
    @(posedge clk_i);
    if (drv.mode == LIUS_MUX) begin
      drv.ale <= 1'h1;
      drv.d <= adr;
      wait_clk(5);
      drv.ale <= 1'h0;
      wait_clk(5);
    end
    drv.addr <= adr[LIUS_AW-1:0];
    drv.d <= wdat;
    drv.pcs_n <= 1'h0;
    drv.pwr_n <= ~wr;
    drv.prd_n <= wr;
    // Wait states while ready is low, bounded so a hang still ends
    for (int n = 0; n < 40; n++) begin
      @(negedge clk_i);
      if (shared_oe_o && !shared_o) lo++;
      if (drv.ack_style ? lo != 0 : lo != 0 && shared_o) break;
    end
    rdat = d_oe_o ? d_o : 8'hXX;
    @(posedge clk_i);
    drv.pcs_n <= 1'h1;
    drv.pwr_n <= 1'h1;
    drv.prd_n <= 1'h1;
    wait_clk(8);
  endtask
endmodule

// >>> testbench/lius_host_port_tb.sv
module lius_host_port_tb
  import lius_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic wr;
    logic [3:0] a;
    logic [31:0] d;
    logic [31:0] x;
  } lius_row_s;
  // Register rows: write, address, write data, expected read data
  localparam lius_row_s ROWS[9] = '{
    '{1'h1, 4'h8, 32'h7, 32'h0}, '{1'h0, 4'h8, 32'h0, 32'h7},
    '{1'h0, 4'h2, 32'h0, 32'h0}, '{1'h1, 4'h2, 32'h5, 32'h0},
    '{1'h0, 4'h2, 32'h0, 32'h0}, '{1'h1, 4'h0, 32'h2, 32'h0},
    '{1'h0, 4'h8, 32'h0, 32'h0}, '{1'h0, 4'h4, 32'h0, 32'h0},
    '{1'h0, 4'hC, 32'h0, 32'h0}};
  localparam logic [7:0] MID = 8'h92;
  localparam logic [7:0] HI = 8'h24;
  logic clk_i = 1'h0;
  logic srst_i = 1'h1;
  logic [3:0] reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'h0;
  logic reg_rd_i = 1'h0;
  logic [31:0] reg_rdata_o, rd;
  lius_pin_s pins;
  logic shared_o, shared_oe_o, d_oe_o, irq_n_o, irq_n_oe_o, rx_term_off_o, irq_o, bad;
  logic [7:0] d_o, r8, lo;
  lius_lb_e [LIUS_CH_N-1:0] loopback_o;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  lius_host_port dut_u (.clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .pins_i(pins), .shared_o(shared_o),
    .shared_oe_o(shared_oe_o), .d_o(d_o), .d_oe_o(d_oe_o), .irq_n_o(irq_n_o),
    .irq_n_oe_o(irq_n_oe_o), .rx_term_off_o(rx_term_off_o), .loopback_o(loopback_o),
    .irq_o(irq_o));
  lius_host_model host_u (.clk_i(clk_i), .shared_o(shared_o), .shared_oe_o(shared_oe_o),
    .d_o(d_o), .d_oe_o(d_oe_o), .pins_o(pins));

  // ************
  // Checks and bus tasks
  // ************
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_lb(input lius_lb_e got, input lius_lb_e exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t loopback %0d exp %0d", $time, got, exp);
    end
  endtask
  // One-cycle strobe; read data taken in the following cycle, then outputs settle
  task automatic reg_acc(input logic wr, input logic [3:0] a, input logic [31:0] d,
                         output logic [31:0] q);
    @(posedge clk_i);
    reg_wr_i <= wr;
    reg_rd_i <= ~wr;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'h0;
    reg_rd_i <= 1'h0;
    @(negedge clk_i);
    q = reg_rdata_o;
    repeat (2) @(negedge clk_i);
  endtask
  // Mode is static, so it only changes under reset; pins need settling after release
  task automatic do_rst(input lius_mode_e m);
    @(posedge clk_i);
    host_u.drv.mode <= m;
    srst_i <= 1'h1;
    repeat (5) @(posedge clk_i);
    srst_i <= 1'h0;
    repeat (6) @(posedge clk_i);
    // Outputs are read away from the edge that launches them
    @(negedge clk_i);
  endtask
  task automatic finish_test();
    $display("n_mismatch %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Hang guard, far above the expected run length
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // ************
  // Main sequence
  // ************
  initial begin
    do_rst(LIUS_SERIAL);
    chk_w({irq_n_oe_o, shared_oe_o, d_oe_o}, 32'h0);
    foreach (ROWS[i]) begin
      reg_acc(ROWS[i].wr, ROWS[i].a, ROWS[i].d, rd);
      if (!ROWS[i].wr) chk_w(rd, ROWS[i].x);
    end
    host_u.ser_frame(8'h06, 8'hA5, r8, bad);
    chk_w(bad, 32'h0);
    reg_acc(1'h1, LIUS_IMASK_OFS, 32'h1, rd);
    chk_w({irq_o, irq_n_oe_o, irq_n_o}, 32'h6);
    reg_acc(1'h1, LIUS_ISTAT_OFS, 32'h1, rd);
    chk_w({irq_o, irq_n_oe_o}, 32'h0);
    for (int e = 0; e < 2; e++) begin
      @(posedge clk_i);
      host_u.drv.edge_sel <= e[0];
      host_u.ser_frame(8'h07, 8'h00, r8, bad);
      chk_w({bad, r8}, 32'hA5);
    end
    reg_acc(1'h1, LIUS_CTRL_OFS, 32'h1, rd);
    reg_acc(1'h1, LIUS_ISTAT_OFS, 32'h1, rd);
    chk_w({irq_o, irq_n_oe_o, irq_n_o}, 32'h3);
    do_rst(LIUS_NONMUX);
    host_u.par_acc(1'h1, 8'h05, 8'h3C, r8, lo);
    chk_w(lo, LIUS_ACC_CYC);
    host_u.par_acc(1'h0, 8'h05, 8'h00, r8, lo);
    chk_w(r8, 32'h3C);
    @(posedge clk_i);
    host_u.drv.ack_style <= 1'h1;
    host_u.par_acc(1'h0, 8'h05, 8'h00, r8, lo);
    chk_w({r8, lo != 0}, 32'h79);
    host_u.par_acc(1'h1, 8'h06, 8'h11, r8, lo);
    chk_w(lo, 32'h1);
    @(posedge clk_i);
    host_u.drv.ack_style <= 1'h0;
    do_rst(LIUS_MUX);
    host_u.par_acc(1'h1, 8'h05, 8'h5A, r8, lo);
    host_u.par_acc(1'h0, 8'hC5, 8'h00, r8, lo);
    chk_w(r8, 32'h5A);
    @(posedge clk_i);
    host_u.drv.shared <= 1'h1;
    host_u.drv.lp_mid <= MID;
    host_u.drv.d <= HI;
    do_rst(LIUS_HW);
    chk_w(rx_term_off_o, 32'h1);
    for (int i = 0; i < LIUS_CH_N; i++) begin
      chk_lb(loopback_o[i], MID[i] ? LIUS_LB_NONE : (HI[i] ? LIUS_LB_ANALOG : LIUS_LB_REMOTE));
    end
    @(posedge clk_i);
    host_u.drv.shared <= 1'h0;
    repeat (8) @(posedge clk_i);
    reg_acc(1'h0, LIUS_ISTAT_OFS, 32'h0, rd);
    chk_w({rd[2:0], irq_o, rx_term_off_o}, 32'h10);
    finish_test();
  end
endmodule
